// file: rtl/ppf_pkg.sv
// Purpose: shared constants of the port pin function and reset block
// Assumes: plain register port, 4-bit word address, 8-bit data
// Notes:   offsets are word indices on the register port
package ppf_pkg;
    // ==========================================================
    // widths
    localparam int P1_WIDTH = 8;
    localparam int P2_WIDTH = 7;
    localparam int P3_WIDTH = 8;
    localparam int ADDR_WIDTH = 4;
    localparam int DATA_WIDTH = 8;

    // ==========================================================
    // register offsets
    localparam logic [3:0] P1_DIR_OFS = 4'h0;
    localparam logic [3:0] P1_OUT_OFS = 4'h1;
    localparam logic [3:0] P1_PU_OFS = 4'h2;
    localparam logic [3:0] P1_IN_OFS = 4'h3;
    localparam logic [3:0] P2_DIR_OFS = 4'h4;
    localparam logic [3:0] P2_OUT_OFS = 4'h5;
    localparam logic [3:0] P2_PU_OFS = 4'h6;
    localparam logic [3:0] P2_IN_OFS = 4'h7;
    localparam logic [3:0] P3_DIR_OFS = 4'h8;
    localparam logic [3:0] P3_OUT_OFS = 4'h9;
    localparam logic [3:0] P3_PU_OFS = 4'ha;
    localparam logic [3:0] P3_IN_OFS = 4'hb;
    localparam logic [3:0] TIMER_CTRL_OFS = 4'hc;
    localparam logic [3:0] PIN_MODE_OFS = 4'hd;

    // ==========================================================
    // field positions
    localparam int ASYNC_SEL_BIT = 0;
    localparam int MODE_XTAL_BIT = 0;
    localparam int MODE_TOSC_BIT = 1;
    localparam int MODE_RSTPIN_BIT = 2;
    localparam int MODE_EXTRST_BIT = 3;
    localparam int OSC_IN_BIT = 6;
    localparam int OSC_OUT_BIT = 7;
    localparam int RESET_PIN_BIT = 6;

    // ==========================================================
    // reset values
    localparam logic [7:0] REG_RESET = 8'h00;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int RESET_MIN_PULSE_NS = 1500;
    localparam int RESET_MIN_CYCLES =
        (RESET_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // external reset filter states
    typedef enum logic [1:0] {
        PPF_RST_IDLE = 2'b00,
        PPF_RST_LOW = 2'b01,
        PPF_RST_HELD = 2'b11
    } ppf_rst_state_type;
endpackage

// file: rtl/ppf_port_bank.sv
// Purpose: one bidirectional port: drive, pull-up and input sampling
// Assumes: pin inputs are asynchronous to clk
// Notes:   direction, drive and pull-up are released by the reset level
//          itself, so the pins float even without a clock
`timescale 1ns/10ps
`default_nettype none
module ppf_port_bank #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic hold_z,
    // settings
    input wire logic [WIDTH-1:0] dir,
    input wire logic [WIDTH-1:0] drive,
    input wire logic [WIDTH-1:0] pull,
    input wire logic [WIDTH-1:0] takeover,
    // pins
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] pin_o,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] pin_pu,
    // sampled level
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] gp_mask;

    // ==========================================================
    // pin gating
    assign gp_mask = hold_z ? '0 : ~takeover;
    assign pin_oe = dir & gp_mask;
    assign pin_o = drive & pin_oe;
    assign pin_pu = pull & ~dir & gp_mask;
    assign level = level_q;

    // ==========================================================
    // two-stage synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            // idle high: the reset pin filter must see no false low
            meta_q <= '1;
            level_q <= '1;
        end else begin
            meta_q <= pin_i;
            level_q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// file: rtl/ppf_pin_mux.sv
// Purpose: three general ports with oscillator and reset pin takeover
// Assumes: fuses are static levels; register port on clk
// Notes:   the reset pin filter needs clk; the clockless float comes
//          from the rst level reaching the pad gating directly
//
// Functional notes
// - port one: eight bidirectional bits, pull-up chosen per bit
// - port two: seven bidirectional bits, pull-up chosen per bit
// - port three: eight bidirectional bits, pull-up chosen per bit
// - every port pin floats while any reset is active, clock or not
// - crystal fuse: port one bit six becomes oscillator amplifier input
// - crystal fuse: port one bit seven becomes oscillator amplifier output
// - RC clock plus async select: port one bits seven, six feed timer
// - reset disable fuse programmed: port two bit six is plain I/O
// - fuse unprogrammed: long enough low on bit six resets the device
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module ppf_pin_mux #(
    parameter int RESET_MIN_CYCLES = ppf_pkg::RESET_MIN_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fuses, high when programmed
    input wire logic crystal_fuse,
    input wire logic reset_disable_fuse,
    // register port
    input wire logic [ppf_pkg::ADDR_WIDTH-1:0] reg_addr,
    input wire logic [ppf_pkg::DATA_WIDTH-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ppf_pkg::DATA_WIDTH-1:0] reg_rdata,
    // port one pins
    input wire logic [ppf_pkg::P1_WIDTH-1:0] port_one_pins_i,
    output logic [ppf_pkg::P1_WIDTH-1:0] port_one_pins_o,
    output logic [ppf_pkg::P1_WIDTH-1:0] port_one_pins_oe,
    output logic [ppf_pkg::P1_WIDTH-1:0] port_one_pins_pu,
    // port two pins
    input wire logic [ppf_pkg::P2_WIDTH-1:0] port_two_pins_i,
    output logic [ppf_pkg::P2_WIDTH-1:0] port_two_pins_o,
    output logic [ppf_pkg::P2_WIDTH-1:0] port_two_pins_oe,
    output logic [ppf_pkg::P2_WIDTH-1:0] port_two_pins_pu,
    // port three pins
    input wire logic [ppf_pkg::P3_WIDTH-1:0] port_three_pins_i,
    output logic [ppf_pkg::P3_WIDTH-1:0] port_three_pins_o,
    output logic [ppf_pkg::P3_WIDTH-1:0] port_three_pins_oe,
    output logic [ppf_pkg::P3_WIDTH-1:0] port_three_pins_pu,
    // pin function status
    output logic crystal_amp_en,
    output logic async_osc_en,
    output logic dev_reset
);
    localparam int CW = $clog2(RESET_MIN_CYCLES + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(RESET_MIN_CYCLES - 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;

    // ==========================================================
    // declarations
    logic [7:0] p1_dir_q, p1_out_q, p1_pu_q;
    logic [6:0] p2_dir_q, p2_out_q, p2_pu_q;
    logic [7:0] p3_dir_q, p3_out_q, p3_pu_q;
    logic async_sel_q;
    logic ext_seen_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [7:0] p1_level;
    logic [6:0] p2_level;
    logic [7:0] p3_level;
    logic [7:0] p1_take;
    logic [6:0] p2_take;
    logic [7:0] p3_take;
    logic xtal_mode, tosc_mode, rstpin_mode;
    logic any_rst;
    logic ext_rst;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    ppf_pkg::ppf_rst_state_type st_q;
    ppf_pkg::ppf_rst_state_type st_d;
    logic [7:0] mode_word;
    logic rst_pin_low;

    // ==========================================================
    // address decode
    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        hit = (a == o);
    endfunction

    wire wr_p1_dir = reg_wr && hit(reg_addr, ppf_pkg::P1_DIR_OFS);
    wire wr_p1_out = reg_wr && hit(reg_addr, ppf_pkg::P1_OUT_OFS);
    wire wr_p1_pu = reg_wr && hit(reg_addr, ppf_pkg::P1_PU_OFS);
    wire wr_p2_dir = reg_wr && hit(reg_addr, ppf_pkg::P2_DIR_OFS);
    wire wr_p2_out = reg_wr && hit(reg_addr, ppf_pkg::P2_OUT_OFS);
    wire wr_p2_pu = reg_wr && hit(reg_addr, ppf_pkg::P2_PU_OFS);
    wire wr_p3_dir = reg_wr && hit(reg_addr, ppf_pkg::P3_DIR_OFS);
    wire wr_p3_out = reg_wr && hit(reg_addr, ppf_pkg::P3_OUT_OFS);
    wire wr_p3_pu = reg_wr && hit(reg_addr, ppf_pkg::P3_PU_OFS);
    wire wr_timer = reg_wr && hit(reg_addr, ppf_pkg::TIMER_CTRL_OFS);
    wire wr_mode = reg_wr && hit(reg_addr, ppf_pkg::PIN_MODE_OFS);

    // ==========================================================
    // pin function selection
    assign xtal_mode = crystal_fuse;
    assign tosc_mode = !crystal_fuse && async_sel_q;
    assign rstpin_mode = !reset_disable_fuse;

    // oscillator pins leave general I/O in either oscillator mode
    assign p1_take = {(xtal_mode || tosc_mode),
                      (xtal_mode || tosc_mode), 6'h00};
    assign p2_take = {rstpin_mode, 6'h00};
    assign p3_take = 8'h00;

    assign crystal_amp_en = xtal_mode;
    assign async_osc_en = tosc_mode;

    // ==========================================================
    // reset combination
    // rst is the chip-level reset level and floats the pads with no
    // clock; the filtered pin reset adds to it once clk runs
    assign any_rst = rst || ext_rst;
    assign dev_reset = any_rst;

    // ==========================================================
    // port banks
    ppf_port_bank #(.WIDTH(ppf_pkg::P1_WIDTH)) u_port_one (
        .clk(clk),
        .rst(rst),
        .hold_z(any_rst),
        .dir(p1_dir_q),
        .drive(p1_out_q),
        .pull(p1_pu_q),
        .takeover(p1_take),
        .pin_i(port_one_pins_i),
        .pin_o(port_one_pins_o),
        .pin_oe(port_one_pins_oe),
        .pin_pu(port_one_pins_pu),
        .level(p1_level)
    );

    ppf_port_bank #(.WIDTH(ppf_pkg::P2_WIDTH)) u_port_two (
        .clk(clk),
        .rst(rst),
        .hold_z(any_rst),
        .dir(p2_dir_q),
        .drive(p2_out_q),
        .pull(p2_pu_q),
        .takeover(p2_take),
        .pin_i(port_two_pins_i),
        .pin_o(port_two_pins_o),
        .pin_oe(port_two_pins_oe),
        .pin_pu(port_two_pins_pu),
        .level(p2_level)
    );

    ppf_port_bank #(.WIDTH(ppf_pkg::P3_WIDTH)) u_port_three (
        .clk(clk),
        .rst(rst),
        .hold_z(any_rst),
        .dir(p3_dir_q),
        .drive(p3_out_q),
        .pull(p3_pu_q),
        .takeover(p3_take),
        .pin_i(port_three_pins_i),
        .pin_o(port_three_pins_o),
        .pin_oe(port_three_pins_oe),
        .pin_pu(port_three_pins_pu),
        .level(p3_level)
    );

    // ==========================================================
    // external reset filter
    // the synchronised level is used; a low shorter than the minimum
    // is dropped, which the board must avoid relying on
    assign rst_pin_low = rstpin_mode && !p2_level[ppf_pkg::RESET_PIN_BIT];
    assign ext_rst = (st_q == ppf_pkg::PPF_RST_HELD);

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            ppf_pkg::PPF_RST_IDLE: begin
                cnt_d = CNT_ZERO;
                if (rst_pin_low) begin
                    st_d = ppf_pkg::PPF_RST_LOW;
                end
            end
            ppf_pkg::PPF_RST_LOW: begin
                if (!rst_pin_low) begin
                    st_d = ppf_pkg::PPF_RST_IDLE;
                end else if (cnt_q == CNT_LAST) begin
                    st_d = ppf_pkg::PPF_RST_HELD;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ppf_pkg::PPF_RST_HELD: begin
                if (!rst_pin_low) begin
                    st_d = ppf_pkg::PPF_RST_IDLE;
                end
            end
            default: begin
                st_d = ppf_pkg::PPF_RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= ppf_pkg::PPF_RST_IDLE;
            cnt_q <= CNT_ZERO;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // ==========================================================
    // control registers, cleared by any reset
    always_ff @(posedge clk) begin
        if (any_rst) begin
            p1_dir_q <= ppf_pkg::REG_RESET;
            p1_out_q <= ppf_pkg::REG_RESET;
            p1_pu_q <= ppf_pkg::REG_RESET;
            p2_dir_q <= ppf_pkg::REG_RESET[6:0];
            p2_out_q <= ppf_pkg::REG_RESET[6:0];
            p2_pu_q <= ppf_pkg::REG_RESET[6:0];
            p3_dir_q <= ppf_pkg::REG_RESET;
            p3_out_q <= ppf_pkg::REG_RESET;
            p3_pu_q <= ppf_pkg::REG_RESET;
            async_sel_q <= 1'b0;
        end else begin
            if (wr_p1_dir) p1_dir_q <= reg_wdata;
            if (wr_p1_out) p1_out_q <= reg_wdata;
            if (wr_p1_pu) p1_pu_q <= reg_wdata;
            if (wr_p2_dir) p2_dir_q <= reg_wdata[6:0];
            if (wr_p2_out) p2_out_q <= reg_wdata[6:0];
            if (wr_p2_pu) p2_pu_q <= reg_wdata[6:0];
            if (wr_p3_dir) p3_dir_q <= reg_wdata;
            if (wr_p3_out) p3_out_q <= reg_wdata;
            if (wr_p3_pu) p3_pu_q <= reg_wdata;
            if (wr_timer) async_sel_q <= reg_wdata[ppf_pkg::ASYNC_SEL_BIT];
        end
    end

    // ==========================================================
    // pin reset flag: survives the pin reset, cleared by writing one
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_seen_q <= 1'b0;
        end else if (ext_rst) begin
            ext_seen_q <= 1'b1;
        end else if (wr_mode && reg_wdata[ppf_pkg::MODE_EXTRST_BIT]) begin
            ext_seen_q <= 1'b0;
        end
    end

    // ==========================================================
    // read path
    always_comb begin
        mode_word = 8'h00;
        mode_word[ppf_pkg::MODE_XTAL_BIT] = xtal_mode;
        mode_word[ppf_pkg::MODE_TOSC_BIT] = tosc_mode;
        mode_word[ppf_pkg::MODE_RSTPIN_BIT] = rstpin_mode;
        mode_word[ppf_pkg::MODE_EXTRST_BIT] = ext_seen_q;
    end

    always_comb begin
        if (hit(reg_addr, ppf_pkg::P1_DIR_OFS)) rdata_d = p1_dir_q;
        else if (hit(reg_addr, ppf_pkg::P1_OUT_OFS)) rdata_d = p1_out_q;
        else if (hit(reg_addr, ppf_pkg::P1_PU_OFS)) rdata_d = p1_pu_q;
        else if (hit(reg_addr, ppf_pkg::P1_IN_OFS)) rdata_d = p1_level;
        else if (hit(reg_addr, ppf_pkg::P2_DIR_OFS)) rdata_d = {1'b0, p2_dir_q};
        else if (hit(reg_addr, ppf_pkg::P2_OUT_OFS)) rdata_d = {1'b0, p2_out_q};
        else if (hit(reg_addr, ppf_pkg::P2_PU_OFS)) rdata_d = {1'b0, p2_pu_q};
        else if (hit(reg_addr, ppf_pkg::P2_IN_OFS)) rdata_d = {1'b0, p2_level};
        else if (hit(reg_addr, ppf_pkg::P3_DIR_OFS)) rdata_d = p3_dir_q;
        else if (hit(reg_addr, ppf_pkg::P3_OUT_OFS)) rdata_d = p3_out_q;
        else if (hit(reg_addr, ppf_pkg::P3_PU_OFS)) rdata_d = p3_pu_q;
        else if (hit(reg_addr, ppf_pkg::P3_IN_OFS)) rdata_d = p3_level;
        else if (hit(reg_addr, ppf_pkg::TIMER_CTRL_OFS))
            rdata_d = {7'h00, async_sel_q};
        else if (hit(reg_addr, ppf_pkg::PIN_MODE_OFS)) rdata_d = mode_word;
        else rdata_d = 8'h00;
    end

    // data stands for the one cycle after the read strobe only
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

// file: dv/ppf_monitor.sv
// Purpose: port pin function checks at the top ports
// Assumes: bound into ppf_pin_mux
// Notes:   pin reset timing is judged from the raw pin level
`timescale 1ns/10ps
`default_nettype none
module ppf_monitor #(
    parameter int RESET_MIN_CYCLES = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fuses and register port
    input wire logic crystal_fuse,
    input wire logic reset_disable_fuse,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins
    input wire logic [7:0] port_one_pins_oe,
    input wire logic [7:0] port_one_pins_pu,
    input wire logic [6:0] port_two_pins_i,
    input wire logic [6:0] port_two_pins_oe,
    input wire logic [6:0] port_two_pins_pu,
    input wire logic [7:0] port_three_pins_oe,
    input wire logic [7:0] port_three_pins_pu,
    // status
    input wire logic crystal_amp_en,
    input wire logic async_osc_en,
    input wire logic dev_reset
);
    // ==========================================================
    // helper: consecutive low cycles on the reset pin
    int low_n;
    always_ff @(posedge clk) begin
        if (rst || reset_disable_fuse || port_two_pins_i[6]) begin
            low_n <= 0;
        end else if (low_n < 1000) begin
            low_n <= low_n + 1;
        end
    end
    wire logic [22:0] oe_all = {port_one_pins_oe, port_two_pins_oe,
        port_three_pins_oe};
    wire logic [22:0] pu_all = {port_one_pins_pu, port_two_pins_pu,
        port_three_pins_pu};

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    sequence pin_held;
        low_n == RESET_MIN_CYCLES + 5;
    endsequence
    sequence pin_rise;
        $rose(dev_reset) && !rst;
    endsequence
    float_rst_a: assert property (rst |-> (oe_all | pu_all) == 0)
        else $error("pins not floating in reset");
    pin_clear_a: assert property (disable iff (rst)
        dev_reset |=> oe_all == 0) else $error("pin reset left drivers");
    pu_excl_a: assert property ((oe_all & pu_all) == 0)
        else $error("pull-up on a driven pin");
    xtal_flag_a: assert property (disable iff (rst)
        crystal_amp_en == crystal_fuse) else $error("crystal flag wrong");
    xtal_pins_a: assert property (crystal_fuse |->
        (port_one_pins_oe[7:6] | port_one_pins_pu[7:6]) == 0)
        else $error("crystal pins used as io");
    async_pins_a: assert property (async_osc_en |->
        !crystal_fuse && (port_one_pins_oe[7:6] | port_one_pins_pu[7:6]) == 0)
        else $error("timer oscillator pins wrong");
    rst_pin_a: assert property (!reset_disable_fuse |->
        !port_two_pins_oe[6] && !port_two_pins_pu[6])
        else $error("reset pin used as io");
    io_pin_a: assert property (disable iff (rst)
        reset_disable_fuse && !$past(rst) |-> !dev_reset)
        else $error("reset from disabled pin");
    pin_long_a: assert property (disable iff (rst)
        pin_held |-> dev_reset) else $error("long low pulse ignored");
    pin_short_a: assert property (disable iff (rst)
        pin_rise |-> low_n >= RESET_MIN_CYCLES)
        else $error("short low pulse reset");
    rd_idle_a: assert property (disable iff (rst)
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
endmodule
`default_nettype wire

// file: dv/ppf_board.sv
// Purpose: board circuitry on one port
// Assumes: device drive beats the board, board beats pull-ups
// Notes:   an undriven pin shows the inverse of its last level
`timescale 1ns/10ps
`default_nettype none
module ppf_board #(
    parameter int WIDTH = 8
) (
    // device side
    input wire logic [WIDTH-1:0] pin_o,
    input wire logic [WIDTH-1:0] pin_oe,
    input wire logic [WIDTH-1:0] pin_pu,
    // board side
    input wire logic [WIDTH-1:0] drv_val,
    input wire logic [WIDTH-1:0] drv_en,
    // resolved wire
    output logic [WIDTH-1:0] pin
);
    logic [WIDTH-1:0] last = '0;
    // floating pins toggle away so a stale level never passes
    always @* begin
        for (int i = 0; i < WIDTH; i++) begin
            if (pin_oe[i]) begin
                pin[i] = pin_o[i];
            end else if (drv_en[i]) begin
                pin[i] = drv_val[i];
            end else if (pin_pu[i]) begin
                pin[i] = 1'b1;
            end else begin
                pin[i] = ~last[i];
            end
            if (pin_oe[i] || drv_en[i] || pin_pu[i]) begin
                last[i] = pin[i];
            end
        end
    end
endmodule
`default_nettype wire

// file: dv/ppf_pin_mux_bench.sv
// Purpose: self-checking bench of the port pin function block
// Assumes: short reset filter count for a quick run
// Notes:   the clock is stopped once to show reset floating without it
`timescale 1ns/10ps
`default_nettype none
module ppf_pin_mux_bench;
    localparam int RMIN = 4;
    localparam logic [7:0] MASK [3] = '{8'hff, 8'h7f, 8'hff};
    logic clk = 1'b0;
    logic run = 1'b1;
    logic rst = 1'b1;
    logic crystal_fuse = 1'b0;
    logic reset_disable_fuse = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] p1_o, p1_oe, p1_pu, p1_pin, p3_o, p3_oe, p3_pu, p3_pin;
    logic [6:0] p2_o, p2_oe, p2_pu, p2_pin;
    logic crystal_amp_en, async_osc_en, dev_reset;
    logic [7:0] dval [3] = '{8'h00, 8'h40, 8'h00};
    logic [7:0] den [3] = '{8'h00, 8'h40, 8'h00};
    logic [7:0] oe_v [3], o_v [3], pu_v [3];
    int mismatches = 0;
    int n_compared = 0;
    assign oe_v = '{p1_oe, {1'b0, p2_oe}, p3_oe};
    assign o_v = '{p1_o, {1'b0, p2_o}, p3_o};
    assign pu_v = '{p1_pu, {1'b0, p2_pu}, p3_pu};

    initial begin
        forever begin
            #12.5;
            if (run) begin
                clk = ~clk;
            end
        end
    end

    ppf_pin_mux #(.RESET_MIN_CYCLES(RMIN)) u_ppf_pin_mux (.clk(clk),
        .rst(rst), .crystal_fuse(crystal_fuse),
        .reset_disable_fuse(reset_disable_fuse), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .port_one_pins_i(p1_pin),
        .port_one_pins_o(p1_o), .port_one_pins_oe(p1_oe),
        .port_one_pins_pu(p1_pu), .port_two_pins_i(p2_pin),
        .port_two_pins_o(p2_o), .port_two_pins_oe(p2_oe),
        .port_two_pins_pu(p2_pu), .port_three_pins_i(p3_pin),
        .port_three_pins_o(p3_o), .port_three_pins_oe(p3_oe),
        .port_three_pins_pu(p3_pu), .crystal_amp_en(crystal_amp_en),
        .async_osc_en(async_osc_en), .dev_reset(dev_reset));
    ppf_board #(.WIDTH(8)) u_ppf_board_one (.pin_o(p1_o), .pin_oe(p1_oe),
        .pin_pu(p1_pu), .drv_val(dval[0]), .drv_en(den[0]), .pin(p1_pin));
    ppf_board #(.WIDTH(7)) u_ppf_board_two (.pin_o(p2_o), .pin_oe(p2_oe),
        .pin_pu(p2_pu), .drv_val(dval[1][6:0]), .drv_en(den[1][6:0]),
        .pin(p2_pin));
    ppf_board #(.WIDTH(8)) u_ppf_board_three (.pin_o(p3_o),
        .pin_oe(p3_oe), .pin_pu(p3_pu), .drv_val(dval[2]),
        .drv_en(den[2]), .pin(p3_pin));

    // ==========================================================
    // tasks
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        cmp(reg_rdata, exp);
        @(posedge clk);
    endtask
    task automatic reboot(input logic cf, input logic rdf);
        rst <= 1'b1;
        crystal_fuse <= cf;
        reset_disable_fuse <= rdf;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic wait_dev(input logic lvl);
        for (int i = 0; i < 100 && dev_reset !== lvl; i++) begin
            @(posedge clk);
            #1;
        end
        if (dev_reset !== lvl) begin
            mismatches++;
            results();
        end
        @(posedge clk);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        logic [3:0] b;
        reboot(1'b0, 1'b1);
        for (int p = 0; p < 3; p++) begin
            b = 4'(p * 4);
            rd(b, 8'h00);
            rd(b + 4'h1, 8'h00);
            rd(b + 4'h2, 8'h00);
            wr(b, 8'hf0);
            wr(b + 4'h1, 8'ha5);
            wr(b + 4'h2, 8'h0f);
            cmp(oe_v[p], 8'hf0 & MASK[p]);
            cmp(o_v[p], 8'ha0 & MASK[p]);
            cmp(pu_v[p], 8'h0f & MASK[p]);
            // pin levels reach the input register two edges late
            repeat (2) @(posedge clk);
            rd(b + 4'h3, 8'haf & MASK[p]);
            wr(b, 8'h00);
            dval[p] <= 8'h5a;
            den[p] <= 8'hff;
            repeat (2) @(posedge clk);
            rd(b + 4'h3, 8'h5a & MASK[p]);
            den[p] <= 8'(p == 1) << 6;
        end
        dval[1] <= 8'h40;
        rd(ppf_pkg::PIN_MODE_OFS, 8'h00);
        rd(4'he, 8'h00);
        wr(ppf_pkg::P1_DIR_OFS, 8'hff);
        wr(ppf_pkg::TIMER_CTRL_OFS, 8'h01);
        cmp({7'h00, async_osc_en}, 8'h01);
        cmp(p1_oe, 8'h3f);
        rd(ppf_pkg::PIN_MODE_OFS, 8'h02);
        reboot(1'b1, 1'b1);
        wr(ppf_pkg::P1_PU_OFS, 8'hff);
        wr(ppf_pkg::TIMER_CTRL_OFS, 8'h01);
        cmp({6'h00, crystal_amp_en, async_osc_en}, 8'h02);
        cmp(p1_pu, 8'h3f);
        wr(ppf_pkg::P1_DIR_OFS, 8'hff);
        cmp(p1_oe, 8'h3f);
        rd(ppf_pkg::PIN_MODE_OFS, 8'h01);
        reboot(1'b0, 1'b0);
        wr(ppf_pkg::P2_DIR_OFS, 8'h7f);
        cmp({1'b0, p2_oe}, 8'h3f);
        rd(ppf_pkg::PIN_MODE_OFS, 8'h04);
        dval[1] <= 8'h00;
        repeat (RMIN - 1) @(posedge clk);
        dval[1] <= 8'h40;
        repeat (8) @(posedge clk);
        cmp({1'b0, p2_oe}, 8'h3f);
        dval[1] <= 8'h00;
        wait_dev(1'b1);
        cmp({1'b0, p2_oe}, 8'h00);
        dval[1] <= 8'h40;
        wait_dev(1'b0);
        rd(ppf_pkg::P2_DIR_OFS, 8'h00);
        rd(ppf_pkg::PIN_MODE_OFS, 8'h0c);
        wr(ppf_pkg::PIN_MODE_OFS, 8'h08);
        rd(ppf_pkg::PIN_MODE_OFS, 8'h04);
        reboot(1'b0, 1'b1);
        dval[1] <= 8'h00;
        wr(ppf_pkg::P3_DIR_OFS, 8'hff);
        wr(ppf_pkg::P3_PU_OFS, 8'hff);
        repeat (RMIN + 8) @(posedge clk);
        cmp({7'h00, dev_reset}, 8'h00);
        cmp(p3_oe, 8'hff);
        @(negedge clk);
        run = 1'b0;
        #40;
        rst = 1'b1;
        #1;
        cmp(p3_oe | p3_pu, 8'h00);
        run = 1'b1;
        results();
    end
endmodule

bind ppf_pin_mux ppf_monitor #(.RESET_MIN_CYCLES(RESET_MIN_CYCLES))
    u_ppf_monitor (.clk(clk), .rst(rst), .crystal_fuse(crystal_fuse),
    .reset_disable_fuse(reset_disable_fuse), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .port_one_pins_oe(port_one_pins_oe),
    .port_one_pins_pu(port_one_pins_pu), .port_two_pins_i(port_two_pins_i),
    .port_two_pins_oe(port_two_pins_oe), .port_two_pins_pu(port_two_pins_pu),
    .port_three_pins_oe(port_three_pins_oe),
    .port_three_pins_pu(port_three_pins_pu),
    .crystal_amp_en(crystal_amp_en), .async_osc_en(async_osc_en),
    .dev_reset(dev_reset));
`default_nettype wire
